//--- pkg/spirp_params.svh
`ifndef SPIRP_PARAMS_SVH
`define SPIRP_PARAMS_SVH
`define SPIRP_NUM_REGS 15
`define SPIRP_LAST_ADDR 7'h0E
`define SPIRP_ADDR_STATUS 7'h00
`define SPIRP_ADDR_PWR 7'h02
`define SPIRP_ADDR_ID 7'h0E
`define SPIRP_BIT_FRESET 0
`define SPIRP_STATUS_MASK 8'h27
`define SPIRP_DEF_01 8'h04
`define SPIRP_DEF_02 8'h06
`define SPIRP_DEF_03 8'h06
`define SPIRP_DEF_04 8'h07
`define SPIRP_DEF_05 8'h11
`define SPIRP_DEF_06 8'h08
`define SPIRP_DEF_07 8'hFA
`define SPIRP_DEF_08 8'h3F
`define SPIRP_DEF_09 8'hFF
`define SPIRP_DEF_0A 8'hF0
`define SPIRP_DEF_0B 8'hF9
`define SPIRP_DEF_0C 8'h4F
`define SPIRP_DEF_0D 8'hE4
`endif

//--- pkg/spirp_pkg.sv
package spirp_pkg;
  typedef enum logic [2:0] {
    SPIRP_IDLE = 3'b001,
    SPIRP_CMD  = 3'b010,
    SPIRP_DATA = 3'b100
  } spirp_state_e;
endpackage

//--- verilog/spirp_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "spirp_params.svh"

// Notes on behaviour
// - Serial traffic is taken only while chip select is low; a high chip select ends the burst.
// - Input data is sampled on rising serial clock edges, most significant bit first.
// - The data output is released whenever chip select is high or no read data is being returned.
// - The map holds fifteen byte-wide registers.
// - The command byte carries a seven-bit address above a read (1) or write (0) bit.
// - Bytes after the command carry data for the addressed register, from the master on write.
// - Each further data byte goes to the next register address.
// - The pointer wraps from fourteen to zero.
// - A read command enables the output driver and shifts registers out from the start address.
// - During a read burst the input data is ignored until chip select rises.
// - Each register is read-only or read-write and takes its default at reset.
// - Writing one to the forced-reset bit returns all registers to their defaults.
module spirp_port #(
  parameter logic [7:0] ID_CODE = 8'h5A  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  // Serial link
  input  wire logic       CS_N,
  input  wire logic       SCLK,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE,
  // Status flags from the device core
  input  wire logic [7:0] STATUS_IN,
  // Register contents to the device core
  output logic [7:0]      REG_OUT [`SPIRP_NUM_REGS]
);

  // ==========================================================
  // Register map defaults
  // SCLK edges are found by oversampling, so each SCLK phase must last at least two clocks
  localparam logic [7:0] DEFS [`SPIRP_NUM_REGS] = '{
    8'h00,          // Status, read-only, not stored
    `SPIRP_DEF_01,
    `SPIRP_DEF_02,
    `SPIRP_DEF_03,
    `SPIRP_DEF_04,
    `SPIRP_DEF_05,
    `SPIRP_DEF_06,
    `SPIRP_DEF_07,
    `SPIRP_DEF_08,
    `SPIRP_DEF_09,
    `SPIRP_DEF_0A,
    `SPIRP_DEF_0B,
    `SPIRP_DEF_0C,
    `SPIRP_DEF_0D,
    8'h00           // Identification, read-only, not stored
  };

  typedef struct packed {
    logic [2:0]            cs_sy;
    logic [2:0]            sck_sy;
    logic [2:0]            sdi_sy;
    logic                  cs_q;
    logic                  sck_q;
    spirp_pkg::spirp_state_e st;
    logic [2:0]            bit_cnt;
    logic [7:0]            shin;
    logic [7:0]            shout;
    logic [6:0]            ptr;
    logic                  rd;
    logic [14:0][7:0]      regs;
    logic [7:0]            stat;
    logic                  sdo;
    logic                  oe;
  } spirp_state_s;

  spirp_state_s s_r;
  spirp_state_s s_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [6:0] spirp_inc(input logic [6:0] a);
    if (a >= `SPIRP_LAST_ADDR)
      spirp_inc = 7'h00;
    else
      spirp_inc = 7'(a + 7'h01);
  endfunction

  // Status and identification bytes are read-only
  function automatic logic spirp_wr_ok(input logic [6:0] a);
    spirp_wr_ok = (a != `SPIRP_ADDR_STATUS) && (a < `SPIRP_LAST_ADDR);
  endfunction

  function automatic logic [7:0] spirp_rd(input spirp_state_s s, input logic [6:0] a);
    if (a == `SPIRP_ADDR_STATUS)
      spirp_rd = s.stat & `SPIRP_STATUS_MASK;
    else if (a == `SPIRP_ADDR_ID)
      spirp_rd = ID_CODE;
    else if (a < 7'(`SPIRP_NUM_REGS))
      spirp_rd = s.regs[a[3:0]];
    else
      spirp_rd = 8'h00;
  endfunction

  // ==========================================================
  // Next state
  logic       cs_low;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] byte_in;

  always_comb begin
    s_nxt = s_r;
    // Synchronise the pins; a chip select or serial clock change counts once the last two stages agree
    s_nxt.cs_sy  = {s_r.cs_sy[1:0], CS_N};
    s_nxt.sck_sy = {s_r.sck_sy[1:0], SCLK};
    s_nxt.sdi_sy = {s_r.sdi_sy[1:0], SDI};
    s_nxt.stat   = STATUS_IN;
    if (s_r.cs_sy[2] == s_r.cs_sy[1])
      s_nxt.cs_q = s_r.cs_sy[2];
    if (s_r.sck_sy[2] == s_r.sck_sy[1])
      s_nxt.sck_q = s_r.sck_sy[2];
    // Edge detection on the filtered serial clock
    cs_low   = !s_nxt.cs_q;
    sck_rise = s_nxt.sck_q && !s_r.sck_q;
    sck_fall = !s_nxt.sck_q && s_r.sck_q;
    byte_in  = {s_r.shin[6:0], s_r.sdi_sy[2]};
    if (!cs_low) begin
      // Chip select high ends the burst and releases the data line
      s_nxt.st      = spirp_pkg::SPIRP_IDLE;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.rd      = 1'b0;
      s_nxt.oe      = 1'b0;
      s_nxt.sdo     = 1'b0;
    end else begin
      case (s_r.st)
        // Burst opened: wait for the command byte
        spirp_pkg::SPIRP_IDLE: begin
          s_nxt.st      = spirp_pkg::SPIRP_CMD;
          s_nxt.bit_cnt = 3'h0;
        end
        // Shift in address and direction
        spirp_pkg::SPIRP_CMD: begin
          if (sck_rise) begin
            s_nxt.shin    = byte_in;
            s_nxt.bit_cnt = 3'(s_r.bit_cnt + 3'h1);
            if (s_r.bit_cnt == 3'h7) begin
              s_nxt.ptr = byte_in[7:1];
              s_nxt.rd  = byte_in[0];
              s_nxt.st  = spirp_pkg::SPIRP_DATA;
              // Preload the first read byte while the command completes
              if (byte_in[0])
                s_nxt.shout = spirp_rd(s_r, byte_in[7:1]);
            end
          end
        end
        // Data bytes, one register each
        spirp_pkg::SPIRP_DATA: begin
          if (s_r.rd) begin
            if (sck_fall) begin
              s_nxt.oe      = 1'b1;
              s_nxt.sdo     = s_r.shout[7];
              s_nxt.shout   = {s_r.shout[6:0], 1'b0};
            end
            if (sck_rise) begin
              s_nxt.bit_cnt = 3'(s_r.bit_cnt + 3'h1);
              if (s_r.bit_cnt == 3'h7) begin
                s_nxt.ptr   = spirp_inc(s_r.ptr);
                s_nxt.shout = spirp_rd(s_r, spirp_inc(s_r.ptr));
              end
            end
          end else if (sck_rise) begin
            s_nxt.shin    = byte_in;
            s_nxt.bit_cnt = 3'(s_r.bit_cnt + 3'h1);
            // Commit only once all eight bits are in
            if (s_r.bit_cnt == 3'h7) begin
              s_nxt.ptr = spirp_inc(s_r.ptr);
              if (spirp_wr_ok(s_r.ptr))
                s_nxt.regs[s_r.ptr[3:0]] = byte_in;
              if (s_r.ptr == `SPIRP_ADDR_PWR && byte_in[`SPIRP_BIT_FRESET]) begin
                for (int i = 0; i < `SPIRP_NUM_REGS; i++) begin
                  s_nxt.regs[i] = DEFS[i];
                end
              end
            end
          end
        end
        default: s_nxt.st = spirp_pkg::SPIRP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      s_r        <= '0;
      s_r.cs_sy  <= 3'h7;
      s_r.cs_q   <= 1'b1;
      s_r.st     <= spirp_pkg::SPIRP_IDLE;
      for (int i = 0; i < `SPIRP_NUM_REGS; i++)
        s_r.regs[i] <= DEFS[i];
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Data output and its enable come straight from flip-flops
  assign SDO    = s_r.sdo;
  assign SDO_OE = s_r.oe;

  // ==========================================================
  // Register contents
  genvar g;
  generate
    for (g = 0; g < `SPIRP_NUM_REGS; g++) begin : g_out
      assign REG_OUT[g] = s_r.regs[g];
    end
  endgenerate

endmodule
`default_nettype wire

//--- verification/spirp_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Checker
module spirp_monitor (
  // Port signals
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  input wire logic       CS_N,
  input wire logic       SCLK,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  input wire logic [7:0] REG_OUT [15]
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence cs_idle; CS_N [*6]; endsequence
  sequence sclk_high; SCLK [*2]; endsequence
  chk_oe_off_cs: assert property (cs_idle |-> !SDO_OE) else $error("driver on while idle");
  chk_regs_hold_cs: assert property (cs_idle |=> $stable(REG_OUT[12])) else $error("reg moved");
  chk_sdo_hold: assert property (sclk_high |-> $stable(SDO)) else $error("sdo moved while high");
  chk_oe_needs_cs: assert property ($rose(SDO_OE) |-> !CS_N) else $error("driver on unselected");
  chk_oe_until_cs: assert property ($fell(SDO_OE) |-> $past(CS_N, 2)) else $error("driver dropped");
  chk_por_clear: assert property (REG_OUT[2][0] == 1'b0) else $error("reset bit stuck");
  chk_ro_zero: assert property (REG_OUT[0] == 8'h00 && REG_OUT[14] == 8'h00) else $error("ro out");
  chk_reset_dflt: assert property ($fell(RESET) |-> REG_OUT[7] == 8'hFA) else $error("bad default");
endmodule
bind spirp_port spirp_monitor i_mon (.CORE_CLK(CORE_CLK), .RESET(RESET), .CS_N(CS_N), .SCLK(SCLK),
  .SDO(SDO), .SDO_OE(SDO_OE), .REG_OUT(REG_OUT));
`default_nettype wire

//--- verification/spirp_master.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Bus master model
module spirp_master (
  // Serial link
  input  wire logic       clk,
  output logic            cs_n,
  output logic            sclk,
  output logic            sdi,
  input  wire logic       sdo_line,
  // Received bytes
  output logic [7:0]      rx_byte,
  output logic            rx_stb
);
  initial begin
    {cs_n, sclk, sdi, rx_byte, rx_stb} = {3'b100, 8'h00, 1'b0};
  end
  // Slow stretches the low phase
  task automatic xfer(input logic [7:0] tx, input int slow);
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (5 + slow) @(negedge clk);
      sclk <= 1'b1;
      rx_byte[i] <= sdo_line;
      repeat (3) @(negedge clk);
      sclk <= 1'b0;
    end
    rx_stb <= 1'b1;
    @(negedge clk);
    rx_stb <= 1'b0;
  endtask
  task automatic burst(input logic [7:0] cmd, input logic [7:0] d [$], input int slow);
    cs_n <= 1'b0;
    repeat (2) @(negedge clk);
    xfer(cmd, slow);
    foreach (d[k]) xfer(d[k], slow);
    repeat (3) @(negedge clk);
    cs_n <= 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "spirp_params.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
// ====
// Testbench
module testbench;
  localparam logic [7:0] ID = 8'hA5; // Arbitrary value
  logic core_clk, reset, cs_n, sclk, sdi, sdo, sdo_oe, rx_stb;
  logic [7:0] status_in, rx_byte, e;
  logic [7:0] reg_out [15];
  logic [7:0] exp_r [15];
  logic [7:0] dflt [15] = '{8'h00, `SPIRP_DEF_01, `SPIRP_DEF_02, `SPIRP_DEF_03, `SPIRP_DEF_04,
    `SPIRP_DEF_05, `SPIRP_DEF_06, `SPIRP_DEF_07, `SPIRP_DEF_08, `SPIRP_DEF_09, `SPIRP_DEF_0A,
    `SPIRP_DEF_0B, `SPIRP_DEF_0C, `SPIRP_DEF_0D, ID};
  logic [7:0] q [$];
  logic [7:0] d [$];
  int failures, checks_done, seed;
  spirp_port #(.ID_CODE(ID)) i_dut (.CORE_CLK(core_clk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .STATUS_IN(status_in), .REG_OUT(reg_out));
  spirp_master i_master (.clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo_line(sdo_oe ? sdo : 1'b0), .rx_byte(rx_byte), .rx_stb(rx_stb));
  always @(posedge rx_stb) begin
    e = q.pop_front();
    `CHK(rx_byte, e)
  end
  task automatic xfer(input logic [6:0] a, input logic rw, input int n, input int slow);
    logic [7:0] b;
    int p;
    d = {};
    q.push_back(8'h00);
    for (int k = 0; k < n; k++) begin
      p = (a + k) % 15;
      b = $random(seed);
      if (p == 2) b[0] = 1'b0;
      d.push_back(b);
      q.push_back(rw ? exp_r[p] : 8'h00);
      if (!rw && p > 0 && p < 14) exp_r[p] = b;
    end
    i_master.burst({a, rw}, d, slow);
  endtask
  task automatic chk_regs(input int t);
    for (int i = 1; i < 14; i++) `CHK(reg_out[i], exp_r[i])
    $display("test %0d done", t);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    seed = 32'h2d2f2708;
    reset = 1'b1;
    status_in = 8'h00;
    exp_r = dflt;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    repeat (6) @(negedge core_clk);
    chk_regs(1);
    status_in = $random(seed);
    exp_r[0] = status_in & `SPIRP_STATUS_MASK;
    xfer(7'h0C, 1'b0, 4, 0);
    chk_regs(2);
    xfer(7'h0D, 1'b1, 5, 2);
    xfer(7'h01, 1'b0, 15, 1);
    xfer(7'h00, 1'b1, 16, 0);
    chk_regs(3);
    q = {8'h00, 8'h00};
    d = {8'h07};
    exp_r = dflt;
    exp_r[0] = status_in & `SPIRP_STATUS_MASK;
    i_master.burst(8'h04, d, 0);
    chk_regs(4);
    xfer(7'h0E, 1'b1, 3, 1);
    chk_regs(5);
    conclude();
  end
endmodule
`default_nettype wire
